// file: cbf_pkg.sv
package cbf_pkg;
    // Frame layout
    localparam int HDR_BYTES = 7;
    localparam int IDX_LEN = 2;
    localparam int IDX_FLAGS = 3;
    localparam int IDX_STN = 4;
    localparam int IDX_TASK = 5;
    localparam int IDX_OP = 6;
    localparam int BUF_BYTES = 32;
    localparam int IDX_W = 5;
    localparam int CNT_W = 6;
    localparam int TXB_BYTES = 16;
    localparam int TXB_W = 4;
    localparam logic [7:0] MAX_LEN_DEF = 8'h20;
    localparam logic [7:0] LINK_FILL = 8'h00;
    // Flags byte
    localparam int FLG_KIND = 7;
    localparam int FLG_SRC_EXT = 6;
    localparam int FLG_DST_EXT = 5;
    localparam int FLG_TRK = 4;
    localparam logic [3:0] FLG_RSVD = 4'h0;
    // Station numbers
    localparam logic [7:0] STN_LOCAL = 8'h00;
    localparam logic [7:0] STN_PARALLEL = 8'hff;
    localparam logic [7:0] STN_OWN_DEF = 8'h01;
    // Tasks and operation codes
    localparam logic [2:0] RAC_TASK = 3'h0;
    localparam logic [7:0] OP_XOR = 8'h0c;
    localparam logic [7:0] OP_PWRITE = 8'h0b;
    localparam logic [7:0] OP_DONE = 8'h00;
    localparam logic [7:0] OP_BAD = 8'hff;
    // Register map of the peer controller
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_HDR = 8'h08;
    localparam logic [1:0] TXB_SEL = 2'h1;
    localparam int CTRL_GO = 0;
    localparam int CTRL_PLEN = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_REPLY = 1;
    localparam int ST_RLEN = 8;
    localparam int HDR_STN = 0;
    localparam int HDR_ORIG = 8;
    localparam int HDR_TGT = 12;
    localparam int HDR_OP = 16;
    localparam int HDR_SRC_EXT = 24;
    localparam int HDR_DST_EXT = 25;
endpackage

// file: cbf_link_if.sv
`timescale 1ns/1ps
interface cbf_link_if;
    // Peer to node bytes
    logic o2d_valid;
    logic [7:0] o2d_data;
    logic o2d_last;
    // Node to peer bytes
    logic d2o_valid;
    logic [7:0] d2o_data;
    logic d2o_last;
    modport node (input o2d_valid, input o2d_data, input o2d_last,
                  output d2o_valid, output d2o_data, output d2o_last);
    modport peer (output o2d_valid, output o2d_data, output o2d_last,
                  input d2o_valid, input d2o_data, input d2o_last);
endinterface

// file: cbf_node.sv
`timescale 1ns/1ps
module cbf_node #(
    parameter logic [7:0] max_len = cbf_pkg::MAX_LEN_DEF,
    parameter logic [7:0] own_station = cbf_pkg::STN_OWN_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link toward the peer
    cbf_link_if.node lk,
    // Local port space
    output logic [7:0] port_addr,
    output logic [7:0] port_wdata,
    output logic port_we,
    input wire logic [7:0] port_rdata,
    // Task engine delivery
    output logic task_valid,
    output logic [2:0] task_num,
    output logic [7:0] task_data,
    output logic task_last,
    // Status
    output logic frame_dropped
);
    import cbf_pkg::*;

    typedef enum logic [2:0] {
        ND_RECV = 3'b000,
        ND_CHECK = 3'b001,
        ND_EXEC_A = 3'b010,
        ND_EXEC_D = 3'b011,
        ND_SEND = 3'b100,
        ND_DELIVER = 3'b101
    } cbf_node_st_t;

    typedef struct packed {
        cbf_node_st_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] idx;
        logic bad;
        logic [BUF_BYTES-1:0][7:0] mem;
        logic [7:0] op_res;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic [7:0] p_addr;
        logic [7:0] p_wdata;
        logic p_we;
        logic t_valid;
        logic [2:0] t_num;
        logic [7:0] t_data;
        logic t_last;
        logic drop;
    } cbf_node_state_t;

    localparam cbf_node_state_t NODE_RST = '0;

    cbf_node_state_t s;
    cbf_node_state_t next_s;

    logic [7:0] len;
    logic [2:0] tgt;
    logic [7:0] op;
    logic [7:0] stn;
    logic good;
    logic [7:0] outv;
    logic [IDX_W-1:0] ia;
    logic [IDX_W-1:0] id;

    assign len = s.mem[IDX_LEN];
    assign tgt = s.mem[IDX_TASK][2:0];
    assign op = s.mem[IDX_OP];
    assign stn = s.mem[IDX_STN];
    assign ia = s.idx[IDX_W-1:0];
    assign id = ia + IDX_W'(1);

    // Link bytes are stored but never inspected for routing
    assign good = !s.bad && ({2'b00, s.cnt} == len)
                  && (len >= 8'(HDR_BYTES)) && (len <= max_len)
                  && !s.mem[IDX_FLAGS][FLG_KIND]
                  && (stn == own_station || stn == STN_LOCAL
                      || stn == STN_PARALLEL);

    // Reply image of one stored byte
    always_comb begin
        outv = s.mem[ia];
        if (s.idx == CNT_W'(IDX_FLAGS)) begin
            outv = s.mem[ia] | (8'h01 << FLG_KIND);
        end else if (s.idx == CNT_W'(IDX_TASK)) begin
            // Origin and target swap roles on the way back
            outv = {s.mem[ia][3:0], s.mem[ia][7:4]};
        end else if (s.idx == CNT_W'(IDX_OP)) begin
            outv = s.op_res;
        end
    end

    always_comb begin
        next_s = s;
        next_s.tx_valid = 1'b0;
        next_s.tx_last = 1'b0;
        next_s.p_we = 1'b0;
        next_s.t_valid = 1'b0;
        next_s.t_last = 1'b0;
        next_s.drop = 1'b0;
        unique case (s.st)
            ND_RECV: begin
                if (lk.o2d_valid) begin
                    // Bytes past the buffer are counted, not stored
                    if (s.cnt < CNT_W'(BUF_BYTES)) begin
                        next_s.mem[s.cnt[IDX_W-1:0]] = lk.o2d_data;
                    end else begin
                        next_s.bad = 1'b1;
                    end
                    if (s.cnt != '1) begin
                        next_s.cnt = s.cnt + CNT_W'(1);
                    end
                    if (lk.o2d_last) begin
                        next_s.st = ND_CHECK;
                    end
                end
            end
            ND_CHECK: begin
                next_s.idx = CNT_W'(HDR_BYTES);
                if (!good) begin
                    next_s.drop = 1'b1;
                    next_s.st = ND_RECV;
                    next_s.cnt = '0;
                    next_s.bad = 1'b0;
                end else if (tgt == RAC_TASK) begin
                    if (op == OP_XOR || op == OP_PWRITE) begin
                        next_s.st = ND_EXEC_A;
                    end else begin
                        next_s.op_res = OP_BAD;
                        next_s.idx = '0;
                        next_s.st = ND_SEND;
                    end
                end else begin
                    next_s.st = ND_DELIVER;
                end
            end
            ND_EXEC_A: begin
                // A trailing odd byte is returned untouched
                if ({2'b00, s.idx} + 8'h01 >= len) begin
                    next_s.op_res = OP_DONE;
                    next_s.idx = '0;
                    next_s.st = ND_SEND;
                end else begin
                    next_s.p_addr = s.mem[ia];
                    next_s.st = ND_EXEC_D;
                end
            end
            ND_EXEC_D: begin
                if (op == OP_XOR) begin
                    next_s.p_wdata = port_rdata ^ s.mem[id];
                end else begin
                    next_s.p_wdata = s.mem[id];
                end
                next_s.p_we = 1'b1;
                // Reply carries the value left in the port
                next_s.mem[id] = next_s.p_wdata;
                next_s.idx = s.idx + CNT_W'(2);
                next_s.st = ND_EXEC_A;
            end
            ND_SEND: begin
                // Reply goes back to the producer over the same link
                next_s.tx_valid = 1'b1;
                next_s.tx_data = outv;
                next_s.idx = s.idx + CNT_W'(1);
                if ({2'b00, s.idx} + 8'h01 == len) begin
                    next_s.tx_last = 1'b1;
                    next_s.st = ND_RECV;
                    next_s.cnt = '0;
                    next_s.bad = 1'b0;
                end
            end
            ND_DELIVER: begin
                // Orders for user tasks go to the consumer task
                if ({2'b00, s.idx} >= len) begin
                    next_s.st = ND_RECV;
                    next_s.cnt = '0;
                    next_s.bad = 1'b0;
                end else begin
                    next_s.t_valid = 1'b1;
                    next_s.t_num = tgt;
                    next_s.t_data = s.mem[ia];
                    next_s.t_last = ({2'b00, s.idx} + 8'h01 == len);
                    next_s.idx = s.idx + CNT_W'(1);
                end
            end
            default: begin
                next_s = NODE_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= NODE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign lk.d2o_valid = s.tx_valid;
    assign lk.d2o_data = s.tx_data;
    assign lk.d2o_last = s.tx_last;
    assign port_addr = s.p_addr;
    assign port_wdata = s.p_wdata;
    assign port_we = s.p_we;
    assign task_valid = s.t_valid;
    assign task_num = s.t_num;
    assign task_data = s.t_data;
    assign task_last = s.t_last;
    assign frame_dropped = s.drop;
endmodule // cbf_node

// file: cbf_peer.sv
`timescale 1ns/1ps
module cbf_peer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Link toward the node
    cbf_link_if.peer lk
);
    import cbf_pkg::*;

    typedef enum logic {
        PR_IDLE = 1'b0,
        PR_SEND = 1'b1
    } cbf_peer_st_t;

    typedef struct packed {
        cbf_peer_st_t st;
        logic wait_n;
        logic [31:0] rdata;
        logic [7:0] stn;
        logic [2:0] orig;
        logic [2:0] tgt;
        logic [7:0] op;
        logic src_ext;
        logic dst_ext;
        logic [TXB_W:0] plen;
        logic [CNT_W-1:0] idx;
        logic [TXB_BYTES-1:0][7:0] txb;
        logic [BUF_BYTES-1:0][7:0] rxb;
        logic [CNT_W-1:0] rx_cnt;
        logic reply;
        logic [7:0] rlen;
        logic o_valid;
        logic [7:0] o_data;
        logic o_last;
    } cbf_peer_state_t;

    localparam cbf_peer_state_t PEER_RST = '0;

    cbf_peer_state_t s;
    cbf_peer_state_t next_s;
    logic take;
    logic commit;
    logic [7:0] flen;
    logic [7:0] fbyte;
    logic [CNT_W-1:0] pi;

    assign take = (avs_read || avs_write) && !s.wait_n;
    // Writes land on the edge that completes the transfer, not when first seen
    assign commit = avs_write && s.wait_n;
    assign flen = 8'(HDR_BYTES) + {3'b000, s.plen};
    assign pi = s.idx - CNT_W'(HDR_BYTES);

    // Frame byte at the send index, in fixed field order
    always_comb begin
        fbyte = s.txb[pi[TXB_W-1:0]];
        if (s.idx < CNT_W'(IDX_LEN)) begin
            fbyte = LINK_FILL;
        end else if (s.idx == CNT_W'(IDX_LEN)) begin
            fbyte = flen;
        end else if (s.idx == CNT_W'(IDX_FLAGS)) begin
            // Order kind, tracking cleared, reserved low bits zero
            fbyte = {1'b0, s.src_ext, s.dst_ext, 1'b0, FLG_RSVD};
        end else if (s.idx == CNT_W'(IDX_STN)) begin
            fbyte = s.stn;
        end else if (s.idx == CNT_W'(IDX_TASK)) begin
            fbyte = {1'b0, s.orig, 1'b0, s.tgt};
        end else if (s.idx == CNT_W'(IDX_OP)) begin
            fbyte = s.op;
        end
    end

    always_comb begin
        next_s = s;
        next_s.o_valid = 1'b0;
        next_s.o_last = 1'b0;
        next_s.wait_n = take;
        if (commit) begin
            if (avs_address == REG_CTRL && s.st == PR_IDLE) begin
                next_s.plen = avs_writedata[CTRL_PLEN +: TXB_W+1];
                if (next_s.plen > (TXB_W+1)'(TXB_BYTES)) begin
                    next_s.plen = (TXB_W+1)'(TXB_BYTES);
                end
                if (avs_writedata[CTRL_GO]) begin
                    next_s.st = PR_SEND;
                    next_s.idx = '0;
                end
            end else if (avs_address == REG_STATUS && avs_writedata[ST_REPLY]) begin
                next_s.reply = 1'b0;
            end else if (avs_address == REG_HDR) begin
                next_s.stn = avs_writedata[HDR_STN +: 8];
                next_s.orig = avs_writedata[HDR_ORIG +: 3];
                next_s.tgt = avs_writedata[HDR_TGT +: 3];
                next_s.op = avs_writedata[HDR_OP +: 8];
                next_s.src_ext = avs_writedata[HDR_SRC_EXT];
                next_s.dst_ext = avs_writedata[HDR_DST_EXT];
            end else if (avs_address[7:6] == TXB_SEL) begin
                next_s.txb[avs_address[TXB_W+1:2]] = avs_writedata[7:0];
            end
        end
        next_s.rdata = '0;
        if (take && avs_read) begin
            if (avs_address == REG_CTRL) begin
                next_s.rdata[CTRL_PLEN +: TXB_W+1] = s.plen;
            end else if (avs_address == REG_STATUS) begin
                next_s.rdata[ST_BUSY] = (s.st == PR_SEND);
                next_s.rdata[ST_REPLY] = s.reply;
                next_s.rdata[ST_RLEN +: 8] = s.rlen;
            end else if (avs_address == REG_HDR) begin
                next_s.rdata[HDR_STN +: 8] = s.stn;
                next_s.rdata[HDR_ORIG +: 3] = s.orig;
                next_s.rdata[HDR_TGT +: 3] = s.tgt;
                next_s.rdata[HDR_OP +: 8] = s.op;
                next_s.rdata[HDR_SRC_EXT] = s.src_ext;
                next_s.rdata[HDR_DST_EXT] = s.dst_ext;
            end else if (avs_address[7:6] == TXB_SEL) begin
                next_s.rdata[7:0] = s.txb[avs_address[TXB_W+1:2]];
            end else if (avs_address[7]) begin
                next_s.rdata[7:0] = s.rxb[avs_address[IDX_W+1:2]];
            end
        end
        if (s.st == PR_SEND) begin
            next_s.o_valid = 1'b1;
            next_s.o_data = fbyte;
            next_s.idx = s.idx + CNT_W'(1);
            if ({2'b00, s.idx} + 8'h01 == flen) begin
                next_s.o_last = 1'b1;
                next_s.st = PR_IDLE;
            end
        end
        if (lk.d2o_valid) begin
            if (s.rx_cnt < CNT_W'(BUF_BYTES)) begin
                next_s.rxb[s.rx_cnt[IDX_W-1:0]] = lk.d2o_data;
            end
            next_s.rx_cnt = s.rx_cnt + CNT_W'(1);
            if (lk.d2o_last) begin
                // Set beats a same-cycle clear
                next_s.reply = 1'b1;
                next_s.rlen = 8'(s.rx_cnt) + 8'h01;
                next_s.rx_cnt = '0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= PEER_RST;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = !s.wait_n;
    assign lk.o2d_valid = s.o_valid;
    assign lk.o2d_data = s.o_data;
    assign lk.o2d_last = s.o_last;
endmodule // cbf_peer

// file: cbf_link_chk.sv
`timescale 1ns/1ps
module cbf_link_chk #(
    parameter logic [7:0] max_len = cbf_pkg::MAX_LEN_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Peer to node
    input wire logic o2d_valid,
    input wire logic [7:0] o2d_data,
    input wire logic o2d_last,
    // Node to peer
    input wire logic d2o_valid,
    input wire logic [7:0] d2o_data,
    input wire logic d2o_last
);
    import cbf_pkg::*;
    logic [7:0] o_idx;
    logic [7:0] d_idx;
    logic [7:0] o_len;
    logic [7:0] d_len;
    logic [7:0] o_flags;
    logic [7:0] o_stn;
    logic [7:0] o_task;

    // Header of the last order is kept so the reply can be judged against it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            o_idx <= 8'h00;
            d_idx <= 8'h00;
            o_len <= 8'h00;
            d_len <= 8'h00;
            o_flags <= 8'h00;
            o_stn <= 8'h00;
            o_task <= 8'h00;
        end else begin
            if (o2d_valid) begin
                o_idx <= o2d_last ? 8'h00 : o_idx + 8'h01;
                o_len <= (o_idx == 8'h02) ? o2d_data : o_len;
                o_flags <= (o_idx == 8'h03) ? o2d_data : o_flags;
                o_stn <= (o_idx == 8'h04) ? o2d_data : o_stn;
                o_task <= (o_idx == 8'h05) ? o2d_data : o_task;
            end
            if (d2o_valid) begin
                d_idx <= d2o_last ? 8'h00 : d_idx + 8'h01;
                d_len <= (d_idx == 8'h02) ? d2o_data : d_len;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_order_link_fill: assert property (o2d_valid && o_idx < 8'h02 |-> o2d_data == LINK_FILL)
        else $error("order link byte not the reserved fill");
    a_reply_link_fill: assert property (d2o_valid && d_idx < 8'h02 |-> d2o_data == LINK_FILL)
        else $error("reply link byte not the reserved fill");
    a_order_len_count: assert property (o2d_valid && o2d_last |-> o_idx + 8'h01 == o_len)
        else $error("order byte count differs from length byte");
    a_reply_len_count: assert property (d2o_valid && d2o_last |-> d_idx + 8'h01 == d_len)
        else $error("reply byte count differs from length byte");
    a_reply_len_range: assert property (d2o_valid && d_idx == 8'h02 |-> d2o_data >= 8'h07 && d2o_data <= max_len)
        else $error("reply length outside accepted range");
    a_order_flags_clean: assert property (o2d_valid && o_idx == 8'h03 |-> (o2d_data & 8'h9f) == 8'h00)
        else $error("order flags kind, tracking or reserved bits set");
    a_reply_flags_kind: assert property (d2o_valid && d_idx == 8'h03 |-> d2o_data == (o_flags | 8'h80))
        else $error("reply flags not order flags with kind set");
    a_reply_station_kept: assert property (d2o_valid && d_idx == 8'h04 |-> d2o_data == o_stn)
        else $error("reply station differs from order station");
    a_reply_tasks_swap: assert property (d2o_valid && d_idx == 8'h05 |-> d2o_data == {o_task[3:0], o_task[7:4]})
        else $error("reply task nibbles not swapped");
    a_order_bytes_run: assert property (o2d_valid && !o2d_last |=> o2d_valid)
        else $error("order frame has a gap");
    a_reply_bytes_run: assert property (d2o_valid && !d2o_last |=> d2o_valid)
        else $error("reply frame has a gap");

    c_reply_done: cover property (d2o_valid && d2o_last);
    c_user_task: cover property (o2d_valid && o_idx == 8'h05 && o2d_data[2:0] != 3'h0);
    c_bare_header: cover property (o2d_valid && o2d_last && o_idx == 8'h06);
endmodule // cbf_link_chk

// file: control_bus_message_framer_bench.sv
`timescale 1ns/1ps
module control_bus_message_framer_bench;
    import cbf_pkg::*;
    typedef struct packed {
        logic [7:0] stn;
        logic [2:0] orig;
        logic [2:0] tgt;
        logic [7:0] op;
        logic [1:0] ext;
        logic [4:0] n;
        logic [1:0] kind;
        logic [63:0] pl;
    } cbf_row_t;
    // Small maximum so an over-long frame fits the peer's 16-byte payload
    localparam logic [7:0] MAXL = 8'h0f;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, port_we, task_valid, task_last, frame_dropped;
    logic [7:0] port_addr, port_wdata, port_rdata, task_data;
    logic [2:0] task_num;
    logic [7:0] ports [256];
    logic [7:0] pm [256];
    logic [7:0] txq [$];
    logic [7:0] rxq [$];
    logic [10:0] tkq [$];
    int errors = 0;
    int checks = 0;
    int rdone = 0;
    int tdone = 0;
    int drops = 0;
    cbf_row_t rows [9];

    cbf_link_if lk ();
    cbf_node #(.max_len(MAXL), .own_station(8'h01)) u_cbf_node (.core_clk(core_clk), .rst(rst),
        .lk(lk), .port_addr(port_addr), .port_wdata(port_wdata), .port_we(port_we),
        .port_rdata(port_rdata), .task_valid(task_valid), .task_num(task_num),
        .task_data(task_data), .task_last(task_last), .frame_dropped(frame_dropped));
    cbf_peer u_cbf_peer (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lk(lk));
    cbf_link_chk #(.max_len(MAXL)) u_cbf_link_chk (.core_clk(core_clk), .rst(rst),
        .o2d_valid(lk.o2d_valid), .o2d_data(lk.o2d_data), .o2d_last(lk.o2d_last),
        .d2o_valid(lk.d2o_valid), .d2o_data(lk.d2o_data), .d2o_last(lk.d2o_last));

    always #2 core_clk = ~core_clk;
    assign port_rdata = ports[port_addr];

    always @(posedge core_clk) begin
        if (port_we === 1'b1) ports[port_addr] <= port_wdata;
        if (lk.o2d_valid === 1'b1) txq.push_back(lk.o2d_data);
        if (lk.d2o_valid === 1'b1) rxq.push_back(lk.d2o_data);
        if (task_valid === 1'b1) tkq.push_back({task_num, task_data});
        if (task_valid === 1'b1 && task_last === 1'b1) tdone++;
        if (lk.d2o_valid === 1'b1 && lk.d2o_last === 1'b1) rdone++;
        if (frame_dropped === 1'b1) drops++;
    end

    function automatic logic [7:0] pay(input cbf_row_t r, input int i);
        return r.pl[8 * (i % 8) +: 8];
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic run(input cbf_row_t r);
        logic [31:0] q;
        logic [55:0] ho;
        logic [55:0] hr;
        logic [7:0] ef [$];
        logic [7:0] er [$];
        logic [7:0] a;
        logic known;
        int r0, t0, d0, k, nn;
        nn = r.n;
        r0 = rdone;
        t0 = tdone;
        d0 = drops;
        known = (r.op == OP_XOR || r.op == OP_PWRITE);
        txq.delete();
        rxq.delete();
        tkq.delete();
        ho = {LINK_FILL, LINK_FILL, 8'(7 + nn), 1'b0, r.ext[0], r.ext[1], 5'h00, r.stn,
              1'b0, r.orig, 1'b0, r.tgt, r.op};
        hr = {ho[55:32], ho[31:24] | 8'h80, r.stn, 1'b0, r.tgt, 1'b0, r.orig,
              known ? OP_DONE : OP_BAD};
        for (int i = 0; i < 7; i++) begin
            ef.push_back(ho[55 - 8 * i -: 8]);
            er.push_back(hr[55 - 8 * i -: 8]);
        end
        av(1'b1, REG_HDR, {6'h0, r.ext, r.op, 1'b0, r.tgt, 1'b0, r.orig, r.stn}, q);
        for (int i = 0; i < nn; i++) begin
            av(1'b1, 8'h40 + 8'(4 * i), {24'h0, pay(r, i)}, q);
            ef.push_back(pay(r, i));
            er.push_back(pay(r, i));
            if (i % 2 == 1 && known && r.kind == 2'd0) begin
                a = pay(r, i - 1);
                pm[a] = (r.op == OP_XOR) ? pm[a] ^ pay(r, i) : pay(r, i);
                er[i + 7] = pm[a];
            end
        end
        av(1'b1, REG_CTRL, {19'h0, 5'(nn), 7'h00, 1'b1}, q);
        for (k = 0; k < 2000 && rdone == r0 && tdone == t0 && drops == d0; k++)
            @(posedge core_clk);
        // Give stray bytes time to show before silence is judged
        repeat (20) @(posedge core_clk);
        chk(32'(txq.size()), 32'(ef.size()));
        foreach (ef[i]) chk({24'h0, txq[i]}, {24'h0, ef[i]});
        if (r.kind == 2'd0) begin
            chk(32'(rxq.size()), 32'(er.size()));
            for (k = 0; k < (known ? er.size() : 7); k++)
                chk({24'h0, rxq[k]}, {24'h0, er[k]});
            av(1'b0, REG_STATUS, 32'h0, q);
            chk(q & 32'hff03, {16'h0, 8'(7 + nn), 8'h02});
            av(1'b0, 8'h88, 32'h0, q);
            chk(q, {24'h0, 8'(7 + nn)});
            av(1'b1, REG_STATUS, 32'h2, q);
            av(1'b0, REG_STATUS, 32'h0, q);
            chk(q & 32'h2, 32'h0);
            foreach (pm[i]) chk({24'h0, ports[i]}, {24'h0, pm[i]});
        end else if (r.kind == 2'd1) begin
            chk(32'(tkq.size()), 32'(nn));
            chk(32'(tdone - t0), 32'h1);
            foreach (tkq[i]) chk({21'h0, tkq[i]}, {21'h0, r.tgt, pay(r, i)});
            chk(32'(rxq.size()), 32'h0);
        end else begin
            chk(32'(drops - d0), 32'h1);
            chk(32'(rxq.size() + tkq.size()), 32'h0);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Whole run needs under a thousand cycles; this leaves wide margin
    initial begin
        repeat (40000) @(posedge core_clk);
        errors++;
        give_verdict();
    end

    initial begin
        for (int i = 0; i < 256; i++) begin
            ports[i] = 8'(i);
            pm[i] = 8'(i);
        end
        rows[0] = '{8'h01, 3'h0, 3'h0, OP_XOR, 2'b01, 5'd4, 2'd0, 64'hffc0ffc2};
        rows[1] = '{8'h00, 3'h0, 3'h0, OP_PWRITE, 2'b10, 5'd5, 2'd0, 64'h773c11a510};
        rows[2] = '{8'hff, 3'h0, 3'h0, OP_XOR, 2'b11, 5'd2, 2'd0, 64'h0f10};
        rows[3] = '{8'h01, 3'h6, 3'h0, 8'h55, 2'b00, 5'd2, 2'd0, 64'h0120};
        rows[4] = '{8'h01, 3'h6, 3'h0, OP_XOR, 2'b00, 5'd0, 2'd0, 64'h0};
        rows[5] = '{8'h01, 3'h2, 3'h5, 8'h21, 2'b01, 5'd3, 2'd1, 64'h332211};
        rows[6] = '{8'h02, 3'h0, 3'h0, OP_XOR, 2'b00, 5'd2, 2'd2, 64'hff30};
        rows[7] = '{8'h01, 3'h0, 3'h0, OP_XOR, 2'b00, 5'd9, 2'd2, 64'hff31ff30ff31ff30};
        rows[8] = '{8'h01, 3'h0, 3'h0, OP_XOR, 2'b00, 5'd8, 2'd0, 64'h0141024203430444};
        repeat (12) @(posedge core_clk);
        chk({27'h0, avs_waitrequest, lk.d2o_valid, task_valid, frame_dropped, port_we}, 32'h10);
        rst <= 1'b0;
        av(1'b1, 8'hf0, 32'h5a5a5a5a, rd);
        av(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        av(1'b0, 8'hfc, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            run(rows[i]);
            $display("test %0d done", i);
        end
        // Reset while an order is on the link, then the link must work again
        av(1'b1, REG_CTRL, {19'h0, 5'd2, 7'h00, 1'b1}, rd);
        repeat (4) @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        @(posedge core_clk);
        chk({29'h0, avs_waitrequest, lk.d2o_valid, lk.o2d_valid}, 32'h4);
        rst <= 1'b0;
        run(rows[0]);
        $display("test mid reset done");
        give_verdict();
    end
endmodule // control_bus_message_framer_bench
